// ### rtl/cmg_regs.sv
// Clock mode and global config registers with Wishbone slave, clock select and port control
// Assumes classic Wishbone master on clk; pin inputs asynchronous and synchronised here
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "cmg_defs.svh"
module cmg_regs (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq,
   input  wire logic        master_mode,
   input  wire logic        sync_ref_present,
   input  wire logic        gapped_clock_in_active,
   input  wire logic        line_signal_lost,
   input  wire logic        alarm_src,
   input  wire logic        mfa_src,
   input  wire logic        bypass_mode,
   input  wire logic        rx_los_pin,
   input  wire logic        rx_rdon_pin,
   input  wire logic        rx_rclk_pin,
   input  wire logic        synth_fsync_n,
   output cmg_pkg::cmg_synth_t   rx_synth_mode,
   output cmg_pkg::cmg_clk_src_t rx_framer_clk_src,
   output cmg_pkg::cmg_clk_src_t tx_framer_clk_src,
   output logic             fsync_from_synth,
   output logic [3:0]       tx_corner_adjust,
   output logic [3:0]       rx_corner_adjust,
   output logic             tx_adjust_active,
   output logic             rx_adjust_active,
   output logic             show_masked_irqs,
   output logic             power_down,
   output logic             receiver_reset_command,
   output logic [2:0]       rx_port_o,
   output logic [2:0]       rx_port_oe,
   output logic [2:0]       rx_port_in,
   output logic [2:0]       rx_port_pullup
);
   import cmg_pkg::*;
   typedef struct packed {
      logic [7:0]  clock_mode_second;
      logic [7:0]  global_configuration;
      logic [7:0]  clock_mode_third;
      logic [7:0]  pc1;
      logic [7:0]  pc2;
      logic [7:0]  pc3;
      logic [2:0]  stat;
      logic [2:0]  mask;
      logic [31:0] rdata;
      logic        ack;
      logic        irq;
      logic        rres;
      cmg_synth_t  smode;
      cmg_clk_src_t rxsrc;
      cmg_clk_src_t txsrc;
      logic [4:0]  s1;
      logic [4:0]  s2;
   } cmg_regs_st_t;
   cmg_regs_st_t st;
   cmg_regs_st_t next_st;
   logic [2:0] ev;
   logic [2:0] fn_in_unused;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] wbyte;

   // Byte lane 0 write with register mask
   function automatic logic [7:0] cmg_wr(input logic [7:0] cur, input logic [7:0] msk);
      cmg_wr = (wb_sel_i[0]) ? (wb_dat_i[7:0] & msk) : cur;
   endfunction

   // Two-flop synchroniser inputs read only from second stage
   wire logic [4:0] pins_raw = {rx_rclk_pin, rx_rdon_pin, rx_los_pin, alarm_src, mfa_src};
   wire logic los_s  = st.s2[2];
   wire logic rdon_s = st.s2[3];
   wire logic rclk_s = st.s2[4];

   cmg_irq u_irq (
      .clk           (clk),
      .resetn        (resetn),
      .src           ({st.s2[0], st.s2[1], line_signal_lost}),
      .both_edge_irq (st.global_configuration[`CMG_B_BOTH]),
      .event_p       (ev)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_port
         logic [7:0] pcv;
         assign pcv = (gi == 0) ? st.pc1 : (gi == 1) ? st.pc2 : st.pc3;
         cmg_port u_port (
            .clk        (clk),
            .resetn     (resetn),
            .fn         (pcv[7:4]),
            .power_down (st.global_configuration[`CMG_B_PD]),
            .fsync_n    (synth_fsync_n | ~st.clock_mode_second[`CMG_B_FPSEL]),
            .no_line_input_flag        (los_s),
            .rdon       (rdon_s),
            .rclk       (rclk_s),
            .pin_o      (rx_port_o[gi]),
            .pin_oe     (rx_port_oe[gi]),
            .is_input   (fn_in_unused[gi])
         );
      end
   endgenerate

   // Writes land at the edge where the master samples ack high
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & st.ack;
   assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st.ack;
   assign wbyte  = wb_dat_i[7:0];

   // Register file, synthesizer and clock source selection, interrupt status
   always_comb begin
      next_st       = st;
      next_st.s1    = pins_raw;
      next_st.s2    = st.s1;
      next_st.ack   = wb_cyc_i & wb_stb_i & ~st.ack;
      next_st.rres  = 1'b0;
      next_st.rdata = 32'h0000_0000;
      if (wr_stb) begin
         case (wb_adr_i)
            `CMG_OFS_CLOCK_MODE_SECOND: next_st.clock_mode_second = cmg_wr(st.clock_mode_second, `CMG_CLOCK_MODE_SECOND_MASK);
            `CMG_OFS_GCR:  next_st.global_configuration  = cmg_wr(st.global_configuration, `CMG_GCR_MASK);
            `CMG_OFS_CLOCK_MODE_THIRD: next_st.clock_mode_third = cmg_wr(st.clock_mode_third, 8'hFF);
            `CMG_OFS_PC1:  next_st.pc1  = cmg_wr(st.pc1, 8'hF0);
            `CMG_OFS_PC2:  next_st.pc2  = cmg_wr(st.pc2, 8'hF0);
            `CMG_OFS_PC3:  next_st.pc3  = cmg_wr(st.pc3, 8'hF0);
            `CMG_OFS_IMASK: next_st.mask = wb_sel_i[0] ? wbyte[2:0] : st.mask;
            `CMG_OFS_RXRES: next_st.rres = wb_sel_i[0] & wbyte[0];
            default: next_st.rres = 1'b0;
         endcase
      end
      // Write one clears; a new event wins over the clear
      if (wr_stb && wb_adr_i == `CMG_OFS_ISTAT && wb_sel_i[0]) begin
         next_st.stat = st.stat & ~wbyte[2:0];
      end
      next_st.stat = next_st.stat | ev;
      if (rd_stb) begin
         case (wb_adr_i)
            `CMG_OFS_CLOCK_MODE_SECOND:  next_st.rdata = {24'h0, st.clock_mode_second};
            `CMG_OFS_GCR:   next_st.rdata = {24'h0, st.global_configuration};
            `CMG_OFS_CLOCK_MODE_THIRD:  next_st.rdata = {24'h0, st.clock_mode_third};
            `CMG_OFS_PC1:   next_st.rdata = {24'h0, st.pc1};
            `CMG_OFS_PC2:   next_st.rdata = {24'h0, st.pc2};
            `CMG_OFS_PC3:   next_st.rdata = {24'h0, st.pc3};
            `CMG_OFS_ISTAT: next_st.rdata = {29'h0, st.global_configuration[`CMG_B_SHOW] ? st.stat
                                                      : (st.stat & ~st.mask)};
            `CMG_OFS_IMASK: next_st.rdata = {29'h0, st.mask};
            `CMG_OFS_EVSRC: next_st.rdata = {29'h0, st.s2[0], st.s2[1], line_signal_lost};
            default:        next_st.rdata = 32'h0000_0000;
         endcase
      end
      // Summary excludes masked bits in every mode
      next_st.irq = |(next_st.stat & ~next_st.mask);
      // Receive synthesizer behaviour when references vanish
      if (!sync_ref_present && (master_mode || line_signal_lost || !gapped_clock_in_active)) begin
         next_st.smode = st.clock_mode_second[`CMG_B_CDIS] ? CMG_SY_FREEZE : CMG_SY_CENTER;
      end else begin
         next_st.smode = CMG_SY_TRACK;
      end
      if (!master_mode && !gapped_clock_in_active && sync_ref_present) begin
         next_st.smode = CMG_SY_TRACK;
      end
      if (bypass_mode) begin
         next_st.rxsrc = CMG_SRC_LINE;
      end else begin
         next_st.rxsrc = st.clock_mode_second[`CMG_B_RXCSEL] ? CMG_SRC_SYNTH : CMG_SRC_SYS;
      end
      next_st.txsrc = st.clock_mode_second[`CMG_B_TXCSEL] ? next_st.rxsrc : CMG_SRC_SYS;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st       <= '0;
         st.clock_mode_second  <= `CMG_RST_CLOCK_MODE_SECOND;
         st.global_configuration   <= `CMG_RST_GCR;
         st.clock_mode_third  <= `CMG_RST_CLOCK_MODE_THIRD;
         st.pc1   <= `CMG_RST_PCAB;
         st.pc2   <= `CMG_RST_PCAB;
         st.pc3   <= `CMG_RST_PCC;
         st.smode <= CMG_SY_TRACK;
         st.rxsrc <= CMG_SRC_SYS;
         st.txsrc <= CMG_SRC_SYS;
      end else begin
         st <= next_st;
      end
   end

   // Registered outputs; power down forces tx_adjust_active and rx_adjust_active low and rx_port_pullup high
   logic [12:0] outq;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         outq <= '0;
      end else begin
         outq[3:0]  <= next_st.clock_mode_third[7:4];
         outq[7:4]  <= next_st.clock_mode_third[3:0];
         outq[8]    <= next_st.clock_mode_second[`CMG_B_TXADJ] & ~next_st.global_configuration[`CMG_B_PD];
         outq[9]    <= next_st.clock_mode_second[`CMG_B_RXADJ] & ~next_st.global_configuration[`CMG_B_PD];
         outq[10]   <= next_st.clock_mode_second[`CMG_B_FPSEL];
         outq[11]   <= next_st.global_configuration[`CMG_B_SHOW];
         outq[12]   <= next_st.global_configuration[`CMG_B_PD];
      end
   end
   logic [2:0] pull_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pull_q <= '0;
         rx_port_in <= '0;
      end else begin
         pull_q     <= {3{st.global_configuration[`CMG_B_PD]}};
         rx_port_in <= fn_in_unused;
      end
   end

   assign wb_dat_o               = st.rdata;
   assign wb_ack_o               = st.ack;
   assign irq                    = st.irq;
   assign rx_synth_mode          = st.smode;
   assign rx_framer_clk_src      = st.rxsrc;
   assign tx_framer_clk_src      = st.txsrc;
   assign tx_corner_adjust       = outq[3:0];
   assign rx_corner_adjust       = outq[7:4];
   assign tx_adjust_active       = outq[8];
   assign rx_adjust_active       = outq[9];
   assign fsync_from_synth       = outq[10];
   assign show_masked_irqs       = outq[11];
   assign power_down             = outq[12];
   assign receiver_reset_command = st.rres;
   assign rx_port_pullup         = pull_q;
endmodule

// ### rtl/cmg_defs.svh
// Offsets, field positions, reset values and codes for the clock mode and global config block
// Assumes byte registers in the low bits of 32-bit Wishbone words
`ifndef CMG_DEFS_SVH
`define CMG_DEFS_SVH
`define CMG_OFS_CLOCK_MODE_SECOND   8'h45
`define CMG_OFS_GCR    8'h46
`define CMG_OFS_CLOCK_MODE_THIRD   8'h47
`define CMG_OFS_PC1    8'h48
`define CMG_OFS_PC2    8'h49
`define CMG_OFS_PC3    8'h4A
`define CMG_OFS_ISTAT  8'h4C
`define CMG_OFS_IMASK  8'h4D
`define CMG_OFS_EVSRC  8'h4E
`define CMG_OFS_RXRES  8'h4F
`define CMG_CLOCK_MODE_SECOND_MASK  8'hFD
`define CMG_GCR_MASK   8'hC1
`define CMG_EV_MASK    8'h07
`define CMG_B_TXADJ    7
`define CMG_B_RXADJ    6
`define CMG_B_CDIS     4
`define CMG_B_FPSEL    3
`define CMG_B_RXCSEL   2
`define CMG_B_TXCSEL   0
`define CMG_B_SHOW     7
`define CMG_B_BOTH     6
`define CMG_B_PD       0
`define CMG_RST_CLOCK_MODE_SECOND   8'h00
`define CMG_RST_GCR    8'h00
`define CMG_RST_CLOCK_MODE_THIRD   8'h00
`define CMG_RST_PCAB   8'h00
`define CMG_RST_PCC    8'hF0
`define CMG_FN_RLT     4'h8
`define CMG_FN_GPI     4'h9
`define CMG_FN_GPOH    4'hA
`define CMG_FN_GPOL    4'hB
`define CMG_FN_LOS     4'hC
`define CMG_FN_TRI     4'hD
`define CMG_FN_RDON    4'hE
`define CMG_FN_RCLK    4'hF
`define CMG_FN_FSYNC   4'h1
`endif

// ### rtl/cmg_pkg.sv
// Types shared by the clock mode and global config block
// Assumes cmg_defs.svh for numbers
package cmg_pkg;
   typedef logic [3:0] cmg_fn_t;
   typedef enum logic [1:0] {CMG_SRC_SYS, CMG_SRC_SYNTH, CMG_SRC_LINE} cmg_clk_src_t;
   typedef enum logic [1:0] {CMG_SY_TRACK, CMG_SY_CENTER, CMG_SY_FREEZE} cmg_synth_t;
endpackage

// ### rtl/cmg_port.sv
// One receive multifunction port: function decode to drive and enable
// Assumes inputs on the block clock; power down handled here
`timescale 1ns/1ns
`include "cmg_defs.svh"
module cmg_port (
   input  wire logic           clk,
   input  wire logic           resetn,
   input  wire cmg_pkg::cmg_fn_t fn,
   input  wire logic           power_down,
   input  wire logic           fsync_n,
   input  wire logic           no_line_input_flag,
   input  wire logic           rdon,
   input  wire logic           rclk,
   output logic                pin_o,
   output logic                pin_oe,
   output logic                is_input
);
   import cmg_pkg::*;
   typedef struct packed {
      logic o;
      logic oe;
      logic in;
   } cmg_port_st_t;
   cmg_port_st_t st;
   cmg_port_st_t next_st;
   // Function select sets value and direction
   always_comb begin
      next_st = '{o: 1'b0, oe: 1'b0, in: 1'b0};
      case (fn)
         `CMG_FN_RLT, `CMG_FN_GPI, `CMG_FN_TRI: next_st.in = 1'b1;
         `CMG_FN_GPOH: next_st = '{o: 1'b1, oe: 1'b1, in: 1'b0};
         `CMG_FN_GPOL: next_st = '{o: 1'b0, oe: 1'b1, in: 1'b0};
         `CMG_FN_LOS:  next_st = '{o: no_line_input_flag, oe: 1'b1, in: 1'b0};
         `CMG_FN_RDON: next_st = '{o: rdon, oe: 1'b1, in: 1'b0};
         `CMG_FN_RCLK: next_st = '{o: rclk, oe: 1'b1, in: 1'b0};
         `CMG_FN_FSYNC: next_st = '{o: fsync_n, oe: 1'b1, in: 1'b0};
         default: next_st = '{o: 1'b0, oe: 1'b0, in: 1'b0};
      endcase
      if (power_down) begin
         next_st = '{o: 1'b0, oe: 1'b0, in: 1'b0};
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign pin_o    = st.o;
   assign pin_oe   = st.oe;
   assign is_input = st.in;
endmodule

// ### rtl/cmg_irq.sv
// Interrupt event shaping: edge detection per source with single or both-edge mode
// Assumes source levels already synchronised
`timescale 1ns/1ns
`include "cmg_defs.svh"
module cmg_irq (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] src,
   input  wire logic       both_edge_irq,
   output logic [2:0]      event_p
);
   import cmg_pkg::*;
   typedef struct packed {
      logic [2:0] prev;
      logic [2:0] ev;
   } cmg_irq_st_t;
   cmg_irq_st_t st;
   cmg_irq_st_t next_st;
   // Rising edge only, or any change when both-edge is on
   always_comb begin
      next_st.prev = src;
      next_st.ev   = both_edge_irq ? (src ^ st.prev) : (src & ~st.prev);
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign event_p = st.ev;
endmodule

// ### verification/cmg_props.sv
// Assertion checker for the clock mode and global config registers
// Assumes it is bound to cmg_regs and sees only that module's ports
`timescale 1ns/1ns
`include "cmg_defs.svh"
module cmg_props
   import cmg_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [7:0]            wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire logic                  sync_ref_present,
   input wire logic                  bypass_mode,
   input wire cmg_synth_t            rx_synth_mode,
   input wire cmg_clk_src_t          rx_framer_clk_src,
   input wire cmg_clk_src_t          tx_framer_clk_src,
   input wire logic [3:0]            tx_corner_adjust,
   input wire logic [3:0]            rx_corner_adjust,
   input wire logic                  tx_adjust_active,
   input wire logic                  rx_adjust_active,
   input wire logic                  show_masked_irqs,
   input wire logic                  power_down,
   input wire logic                  receiver_reset_command,
   input wire logic [2:0]            rx_port_oe,
   input wire logic [2:0]            rx_port_pullup
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Write taken at the ack edge for one register
   sequence s_wr(logic [7:0] a);
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
   endsequence
   property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
   property p_gcr; s_wr(`CMG_OFS_GCR) |=> show_masked_irqs == $past(wb_dat_i[7])
      && power_down == $past(wb_dat_i[0]); endproperty
   property p_corner; s_wr(`CMG_OFS_CLOCK_MODE_THIRD) |=> tx_corner_adjust == $past(wb_dat_i[7:4])
      && rx_corner_adjust == $past(wb_dat_i[3:0]); endproperty
   property p_rxres; s_wr(`CMG_OFS_RXRES) ##0 wb_dat_i[0]
      |=> receiver_reset_command ##1 !receiver_reset_command; endproperty
   property p_rdzero; wb_ack_o && !wb_we_i && wb_adr_i == `CMG_OFS_GCR
      |-> wb_dat_o[5:1] == 5'h00; endproperty
   property p_track; sync_ref_present |=> rx_synth_mode == CMG_SY_TRACK; endproperty
   property p_bypass; bypass_mode |=> rx_framer_clk_src == CMG_SRC_LINE; endproperty
   property p_txsrc; tx_framer_clk_src != CMG_SRC_SYS
      |-> tx_framer_clk_src == rx_framer_clk_src; endproperty
   property p_pd_port; power_down && $past(power_down, 2)
      |-> rx_port_oe == 3'h0 && rx_port_pullup == 3'h7; endproperty
   property p_pd_adj; power_down && $past(power_down)
      |-> !tx_adjust_active && !rx_adjust_active; endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
   a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
   a_gcr: assert property (p_gcr) else $error("global config bits not applied");
   a_corner: assert property (p_corner) else $error("corner adjust wrong");
   a_rxres: assert property (p_rxres) else $error("receiver reset pulse wrong");
   a_rdzero: assert property (p_rdzero) else $error("reserved bits not zero");
   a_track: assert property (p_track) else $error("synth not tracking");
   a_bypass: assert property (p_bypass) else $error("bypass clock wrong");
   a_txsrc: assert property (p_txsrc) else $error("tx clock not rx clock");
   a_pd_port: assert property (p_pd_port) else $error("ports active in power down");
   a_pd_adj: assert property (p_pd_adj) else $error("adjust active in power down");
endmodule
bind cmg_regs cmg_props u_props (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sync_ref_present, .bypass_mode, .rx_synth_mode,
   .rx_framer_clk_src, .tx_framer_clk_src, .tx_corner_adjust, .rx_corner_adjust,
   .tx_adjust_active, .rx_adjust_active, .show_masked_irqs, .power_down,
   .receiver_reset_command, .rx_port_oe, .rx_port_pullup);

// ### verification/cmg_far.sv
// Far-side framer model: line status sources and synthesizer frame pulse
// Assumes the bench commands source levels on ev_req, one clock domain
`timescale 1ns/1ns
module cmg_far (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] ev_req,
   output logic            line_signal_lost,
   output logic            alarm_src,
   output logic            mfa_src,
   output logic            synth_fsync_n
);
   logic [2:0] cnt;
   // Sources follow the command a cycle late; frame pulse low every eighth cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {mfa_src, alarm_src, line_signal_lost} <= 3'h0;
         cnt <= 3'h0;
         synth_fsync_n <= 1'b1;
      end else begin
         {mfa_src, alarm_src, line_signal_lost} <= ev_req;
         cnt <= cnt + 3'h1;
         synth_fsync_n <= (cnt != 3'h7);
      end
   end
endmodule

// ### verification/testbench.sv
// Self-checking bench for the clock mode and global config registers
// Assumes cmg_regs as top, Wishbone master tasks, far-side model cmg_far
`timescale 1ns/1ns
`include "cmg_defs.svh"
module testbench;
   import cmg_pkg::*;
   logic        clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, irq, master_mode = 0, sync_ref_present = 1, bypass_mode = 0;
   logic [2:0]  ev = 3'h0, rx_port_o, rx_port_oe, rx_port_in, rx_port_pullup;
   logic        line_signal_lost, alarm_src, mfa_src, synth_fsync_n, fsync_from_synth;
   logic        tx_adjust_active, rx_adjust_active, show_masked_irqs, power_down, rrc;
   logic [3:0]  tx_corner_adjust, rx_corner_adjust;
   cmg_synth_t   rx_synth_mode;
   cmg_clk_src_t rx_framer_clk_src, tx_framer_clk_src;
   int          n_fail = 0, n_tests = 0, ticks = 0;
   logic [7:0]  offs [6] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A};
   logic [7:0]  rsts [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0};
   cmg_far far (.clk, .resetn, .ev_req(ev), .line_signal_lost, .alarm_src, .mfa_src,
      .synth_fsync_n);
   cmg_regs dut (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .master_mode, .sync_ref_present,
      .gapped_clock_in_active(1'b1), .line_signal_lost, .alarm_src, .mfa_src, .bypass_mode,
      .rx_los_pin(1'b0), .rx_rdon_pin(1'b0), .rx_rclk_pin(1'b0), .synth_fsync_n,
      .rx_synth_mode, .rx_framer_clk_src, .tx_framer_clk_src, .fsync_from_synth,
      .tx_corner_adjust, .rx_corner_adjust, .tx_adjust_active, .rx_adjust_active,
      .show_masked_irqs, .power_down, .receiver_reset_command(rrc), .rx_port_o, .rx_port_oe,
      .rx_port_in, .rx_port_pullup);
   // Clock and hang guard
   always #5 clk = ~clk;
   always @(posedge clk) begin
      ticks <= ticks + 1;
      if (ticks == 20000) begin
         n_fail = n_fail + 1;
         conclude();
      end
   end
   task automatic conclude();
      if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One classic Wishbone cycle; read data taken at the ack edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
      int t;
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'h1};
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      if (t >= 50) n_fail = n_fail + 1;
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 8'h00, q);
      chk(q, {24'h0, e});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Main sequence
   initial begin
      idle(4);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(offs[i], rsts[i]);
      chk(rx_port_oe, 3'h4);
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00);
      wr(`CMG_OFS_CLOCK_MODE_SECOND, 8'hFF);
      rd(`CMG_OFS_CLOCK_MODE_SECOND, 8'hFD);
      idle(3);
      chk({fsync_from_synth, rx_framer_clk_src, tx_framer_clk_src}, 5'b1_01_01);
      bypass_mode <= 1'b1;
      idle(3);
      chk({rx_framer_clk_src, tx_framer_clk_src}, 4'b10_10);
      bypass_mode <= 1'b0;
      wr(`CMG_OFS_CLOCK_MODE_SECOND, 8'h08);
      idle(3);
      chk({fsync_from_synth, rx_framer_clk_src, tx_framer_clk_src}, 5'b1_00_00);
      {master_mode, sync_ref_present} <= 2'b10;
      idle(3);
      chk(rx_synth_mode, CMG_SY_CENTER);
      wr(`CMG_OFS_CLOCK_MODE_SECOND, 8'h10);
      idle(3);
      chk(rx_synth_mode, CMG_SY_FREEZE);
      sync_ref_present <= 1'b1;
      idle(3);
      chk(rx_synth_mode, CMG_SY_TRACK);
      wr(`CMG_OFS_CLOCK_MODE_THIRD, 8'hA5);
      idle(2);
      chk({tx_corner_adjust, rx_corner_adjust}, 8'hA5);
      for (int c = 8; c < 16; c++) begin
         wr(`CMG_OFS_PC1, 8'(c << 4));
         idle(4);
         chk({rx_port_oe[0], rx_port_in[0]},
             {1'((8'hDC >> (c - 8)) & 8'h01), 1'(~(8'hDC >> (c - 8)))});
         if (c == 10 || c == 11) chk(rx_port_o[0], c == 10);
      end
      wr(`CMG_OFS_PC2, 8'hA0);
      idle(4);
      chk(rx_port_oe, 3'h7);
      wr(`CMG_OFS_GCR, 8'hFF);
      rd(`CMG_OFS_GCR, 8'hC1);
      idle(4);
      chk({rx_port_oe, rx_port_pullup, tx_adjust_active, rx_adjust_active}, 8'h1C);
      wr(`CMG_OFS_GCR, 8'h40);
      wr(`CMG_OFS_RXRES, 8'h01);
      @(posedge clk);
      chk(rrc, 1'b1);
      @(posedge clk);
      chk(rrc, 1'b0);
      wr(`CMG_OFS_ISTAT, 8'hFF);
      ev <= 3'h2;
      idle(8);
      chk(irq, 1'b1);
      rd(`CMG_OFS_ISTAT, 8'h02);
      wr(`CMG_OFS_ISTAT, 8'h02);
      idle(2);
      chk(irq, 1'b0);
      ev <= 3'h0;
      idle(8);
      chk(irq, 1'b1);
      wr(`CMG_OFS_IMASK, 8'h02);
      wr(`CMG_OFS_GCR, 8'h00);
      wr(`CMG_OFS_ISTAT, 8'h02);
      ev <= 3'h2;
      idle(8);
      chk(irq, 1'b0);
      rd(`CMG_OFS_ISTAT, 8'h00);
      wr(`CMG_OFS_GCR, 8'h80);
      rd(`CMG_OFS_ISTAT, 8'h02);
      wr(`CMG_OFS_ISTAT, 8'h02);
      ev <= 3'h0;
      idle(8);
      rd(`CMG_OFS_ISTAT, 8'h00);
      conclude();
   end
endmodule
